// file: omc_host.sv
// Host controller end: Wishbone registers, transmit-off pin and two-wire master.
`timescale 1ns/1ps
`default_nettype none
`include "omc_regs.svh"
module omc_host #(
  parameter int unsigned GAP_CYC = `OMC_GAP_CYC,
  parameter int unsigned READY_CYC = `OMC_READY_CYC
) (
  input wire logic clk,
  input wire logic srst,
  omc_link_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);

  localparam logic [25:0] READY_LIM = 26'(READY_CYC - 1);
  localparam logic [20:0] GAP_LIM = 21'(GAP_CYC - 1);
  localparam logic [10:0] HIGH_LIM = 11'(`OMC_RESET_CYC - 1);
  localparam logic [11:0] QTR_LIM = 12'(`OMC_QTR_CYC - 1);
  localparam logic [11:0] BUF_LIM = 12'(`OMC_BUF_CYC - 1);

  omc_pkg::omc_host_t h_q, h_d;
  logic take, adv, sending;

  // Byte sent at a position of the transaction.
  function automatic logic [7:0] txByte(input omc_pkg::omc_host_t h, input logic [1:0] i);
    logic [7:0] a;
    a = h.page ? `OMC_DEV_A2 : `OMC_DEV_A0;
    unique case (i)
      2'd0: return a;
      2'd1: return h.regAdr;
      2'd2: return h.isRead ? (a | 8'h01) : h.wrData;
      default: return 8'hFF;
    endcase
  endfunction

  assign take = wb_cyc_i & wb_stb_i & ~h_q.ack;
  // A quarter ends on time, but the first high quarter (phase 1) waits for a released clock.
  assign adv = h_q.cnt == QTR_LIM && (h_q.ph != 2'd1 || h_q.sclS2);
  assign sending = ~(h_q.isRead & (h_q.idx == 2'd3));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole controller.
  always_comb
  begin
    h_d = h_q;
    h_d.sclS1 = link.scl;
    h_d.sclS2 = h_q.sclS1;
    h_d.sdaS1 = link.sda;
    h_d.sdaS2 = h_q.sdaS1;
    h_d.fltS1 = link.laserFault;
    h_d.fltS2 = h_q.fltS1;
    h_d.fltPrev = h_q.fltS2;
    h_d.losS1 = link.rxLost;
    h_d.losS2 = h_q.losS1;
    h_d.losPrev = h_q.losS2;
    if (h_q.readyCnt != READY_LIM)
    begin
      h_d.readyCnt = h_q.readyCnt + 26'h0000001;
    end

    // Transmit-off pin: spaced rises, and a held-high least time.
    if (h_q.gapCnt != GAP_LIM)
    begin
      h_d.gapCnt = h_q.gapCnt + 21'h000001;
    end
    if (h_q.txPin && h_q.highCnt != HIGH_LIM)
    begin
      h_d.highCnt = h_q.highCnt + 11'h001;
    end
    if (!h_q.txPin && h_q.ctrlTxOff && h_q.gapCnt == GAP_LIM)
    begin
      h_d.txPin = 1'b1;
      h_d.gapCnt = '0;
      h_d.highCnt = '0;
    end
    else if (h_q.txPin && !h_q.ctrlTxOff && h_q.highCnt == HIGH_LIM)
    begin
      h_d.txPin = 1'b0;
    end

    // Two-wire master sequencer.
    h_d.cnt = (h_q.cnt == QTR_LIM) ? '0 : h_q.cnt + 12'h001;
    if (h_q.cnt == QTR_LIM && !adv)
    begin
      h_d.cnt = h_q.cnt;
    end
    unique case (h_q.st)
      omc_pkg::HIDLE:
      begin
        h_d.cnt = '0;
        h_d.sclOe = 1'b0;
        h_d.sdaOe = 1'b0;
        if (h_q.pend && h_q.readyCnt == READY_LIM)
        begin
          h_d.st = omc_pkg::HSTART;
          h_d.ph = '0;
          h_d.idx = '0;
          h_d.nack = 1'b0;
          h_d.shr = txByte(h_q, 2'd0);
        end
      end
      omc_pkg::HSTART:
      begin
        h_d.sdaOe = h_q.ph[1];
        h_d.sclOe = (h_q.ph == 2'd0) | (h_q.ph == 2'd3);
        if (adv)
        begin
          h_d.ph = h_q.ph + 2'd1;
          if (h_q.ph == 2'd3)
          begin
            h_d.st = omc_pkg::HBIT;
            h_d.bitCnt = '0;
          end
        end
      end
      omc_pkg::HBIT:
      begin
        h_d.sclOe = (h_q.ph == 2'd0) | (h_q.ph == 2'd3);
        h_d.sdaOe = sending & (h_q.bitCnt != 4'h8) & ~h_q.shr[7];
        if (adv)
        begin
          h_d.ph = h_q.ph + 2'd1;
          if (h_q.ph == 2'd2)
          begin
            if (h_q.bitCnt != 4'h8)
            begin
              h_d.shr = {h_q.shr[6:0], h_q.sdaS2};
            end
            else if (sending && h_q.sdaS2)
            begin
              h_d.nack = 1'b1;
            end
          end
          if (h_q.ph == 2'd3)
          begin
            h_d.bitCnt = h_q.bitCnt + 4'h1;
            if (h_q.bitCnt == 4'h8)
            begin
              h_d.bitCnt = '0;
              h_d.idx = h_q.idx + 2'd1;
              h_d.shr = txByte(h_q, h_q.idx + 2'd1);
              if (h_q.nack || (!h_q.isRead && h_q.idx == 2'd2) || h_q.idx == 2'd3)
              begin
                h_d.st = omc_pkg::HSTOP;
                h_d.rdData = h_q.isRead ? h_q.shr : h_q.rdData;
              end
              else if (h_q.isRead && h_q.idx == 2'd1)
              begin
                h_d.st = omc_pkg::HSTART;
              end
            end
          end
        end
      end
      omc_pkg::HSTOP:
      begin
        h_d.sdaOe = ~h_q.ph[1];
        h_d.sclOe = h_q.ph == 2'd0;
        if (adv)
        begin
          h_d.ph = h_q.ph + 2'd1;
          if (h_q.ph == 2'd2)
          begin
            h_d.st = omc_pkg::HBUF;
            h_d.cnt = '0;
          end
        end
      end
      omc_pkg::HBUF:
      begin
        h_d.cnt = h_q.cnt + 12'h001;
        if (h_q.cnt == BUF_LIM)
        begin
          h_d.st = omc_pkg::HIDLE;
          h_d.pend = 1'b0;
        end
      end
      default:
      begin
        h_d.st = omc_pkg::HIDLE;
      end
    endcase

    // Wishbone slave: answer one cycle after the strobe.
    h_d.ack = take;
    h_d.rdat = '0;
    if (take && wb_we_i && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        `OMC_WB_CTRL: h_d.ctrlTxOff = wb_dat_i[0];
        `OMC_WB_MASK: h_d.irqMask = wb_dat_i[2:0];
        `OMC_WB_CMD:
        begin
          if (!h_q.pend)
          begin
            h_d.pend = 1'b1;
            h_d.regAdr = wb_dat_i[7:0];
            h_d.wrData = wb_dat_i[15:8];
            h_d.isRead = wb_dat_i[16];
            h_d.page = wb_dat_i[17];
          end
        end
        default: h_d.rdat = '0;
      endcase
    end
    if (take && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `OMC_WB_CTRL: h_d.rdat = {31'h0, h_q.ctrlTxOff};
        `OMC_WB_CMD: h_d.rdat = {14'h0, h_q.page, h_q.isRead, h_q.wrData, h_q.regAdr};
        `OMC_WB_STAT: h_d.rdat = {13'h0, h_q.txPin, h_q.losS2, h_q.fltS2, h_q.rdData,
                                  6'h0, h_q.nack, h_q.pend};
        `OMC_WB_IRQ: h_d.rdat = {29'h0, h_q.irqStat};
        `OMC_WB_MASK: h_d.rdat = {29'h0, h_q.irqMask};
        default: h_d.rdat = '0;
      endcase
    end

    // Sticky events; a read clears them, but a new event wins.
    if (take && !wb_we_i && wb_adr_i == `OMC_WB_IRQ)
    begin
      h_d.irqStat = '0;
    end
    if (h_q.st == omc_pkg::HBUF && h_q.cnt == BUF_LIM)
    begin
      h_d.irqStat[`OMC_IRQ_DONE] = 1'b1;
    end
    if (h_q.fltS2 && !h_q.fltPrev)
    begin
      h_d.irqStat[`OMC_IRQ_FAULT] = 1'b1;
    end
    if (h_q.losS2 != h_q.losPrev)
    begin
      h_d.irqStat[`OMC_IRQ_LOS] = 1'b1;
    end
    h_d.irq = |(h_d.irqStat & h_d.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset; the clock and data pins idle high.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      h_q <= '0;
      h_q.sclS1 <= 1'b1;
      h_q.sclS2 <= 1'b1;
      h_q.sdaS1 <= 1'b1;
      h_q.sdaS2 <= 1'b1;
      h_q.gapCnt <= GAP_LIM;
      h_q.st <= omc_pkg::HIDLE;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  // Outputs straight from the state register.
  assign wb_dat_o = h_q.rdat;
  assign wb_ack_o = h_q.ack;
  assign irq = h_q.irq;
  assign link.txOffPin = h_q.txPin;
  assign link.sclHostOe = h_q.sclOe;
  assign link.sdaHostOe = h_q.sdaOe;

endmodule
`default_nettype wire

// file: omc_regs.svh
// Offsets, bit positions, addresses and timing counts of the optical module control block.
`ifndef OMC_REGS_SVH
`define OMC_REGS_SVH

// Clock rate and printed times.
`define OMC_CLK_MHZ 125
`define OMC_T_RESET_US 10
`define OMC_T_ON_MS 2
`define OMC_T_GAP_MS 10
`define OMC_T_READY_MS 300
`define OMC_T_BUF_US 20
`define OMC_F_SCL_KHZ 400

// Cycle counts derived from the times; least times round up.
`define OMC_RESET_CYC (`OMC_T_RESET_US * `OMC_CLK_MHZ)
`define OMC_ON_CYC (`OMC_T_ON_MS * 1000 * `OMC_CLK_MHZ)
`define OMC_GAP_CYC (`OMC_T_GAP_MS * 1000 * `OMC_CLK_MHZ)
`define OMC_READY_CYC (`OMC_T_READY_MS * 1000 * `OMC_CLK_MHZ)
`define OMC_BUF_CYC (`OMC_T_BUF_US * `OMC_CLK_MHZ)
`define OMC_QTR_CYC ((`OMC_CLK_MHZ * 1000 + 4 * `OMC_F_SCL_KHZ - 1) / (4 * `OMC_F_SCL_KHZ))

// Two-wire device addresses and the control and status byte.
`define OMC_DEV_A0 8'hA0
`define OMC_DEV_A2 8'hA2
`define OMC_CSB_OFS 8'h6E
`define OMC_CSB_SOFTOFF 6
`define OMC_CSB_FAULT 2
`define OMC_CSB_LOS 1
`define OMC_CSB_READY 0

// Host controller Wishbone register byte offsets.
`define OMC_WB_CTRL 8'h00
`define OMC_WB_CMD 8'h04
`define OMC_WB_STAT 8'h08
`define OMC_WB_IRQ 8'h0C
`define OMC_WB_MASK 8'h10

// Interrupt status bits.
`define OMC_IRQ_DONE 0
`define OMC_IRQ_FAULT 1
`define OMC_IRQ_LOS 2

`endif

// file: omc_pkg.sv
// Types shared by both ends of the optical module control block.
package omc_pkg;

  // Two-wire slave states inside the module.
  typedef enum logic [2:0] {SIDLE, SADDR, SRX, SACK, STX, SMACK} omc_dev_st_t;

  // Two-wire master states inside the host.
  typedef enum logic [2:0] {HIDLE, HSTART, HBIT, HSTOP, HBUF} omc_host_st_t;

  // Whole state of the module end.
  typedef struct packed {
    logic txS1, txS2, sclS1, sclS2, sclPrev, sdaS1, sdaS2, sdaPrev;
    logic fdS1, fdS2, spS1, spS2;
    logic [17:0] onCnt;
    logic ready;
    logic [10:0] highCnt;
    logic faultLat, softOff, laserOn, faultOut, losOut, sclOe, sdaOe;
    omc_dev_st_t st;
    logic [3:0] bitCnt;
    logic [7:0] shr, ptr;
    logic first, rw, selA2, wrPend, wrVal;
  } omc_dev_t;

  // Whole state of the host end.
  typedef struct packed {
    logic sclS1, sclS2, sdaS1, sdaS2, fltS1, fltS2, fltPrev, losS1, losS2, losPrev;
    logic [25:0] readyCnt;
    logic [20:0] gapCnt;
    logic [10:0] highCnt;
    logic txPin, ctrlTxOff;
    logic pend, isRead, page, nack;
    logic [7:0] regAdr, wrData, rdData, shr;
    omc_host_st_t st;
    logic [1:0] ph;
    logic [3:0] bitCnt;
    logic [1:0] idx;
    logic [11:0] cnt;
    logic sclOe, sdaOe;
    logic [2:0] irqStat, irqMask;
    logic irq, ack;
    logic [31:0] rdat;
  } omc_host_t;

endpackage

// file: omc_link_if.sv
// Pins between the host controller and the optical module.
`timescale 1ns/1ps
`default_nettype none
interface omc_link_if;
  logic txOffPin;
  logic laserFault;
  logic rxLost;
  logic sclHostOe;
  logic sdaHostOe;
  logic sclDevOe;
  logic sdaDevOe;
  logic scl;
  logic sda;

  // Open-drain wires: low while either end drives, pulled high otherwise.
  assign scl = ~(sclHostOe | sclDevOe);
  assign sda = ~(sdaHostOe | sdaDevOe);

  modport dev (input txOffPin, scl, sda, output laserFault, rxLost, sclDevOe, sdaDevOe);
  modport host (input laserFault, rxLost, scl, sda, output txOffPin, sclHostOe, sdaHostOe);
endinterface
`default_nettype wire

// file: omc_module.sv
// Control, status and two-wire slave logic of the optical module end.
//
// Function
// - Transmit-off rise darkens laser within 10 us.
// - Host spaces transmit-off assertions by 10 ms.
// - Transmit-off fall restores light within 2 ms.
// - Initialise within 300 ms, clearing fault.
// - Laser fault output within 1 ms.
// - 10 us transmit-off pulse clears latched fault.
// - Signal-lost output rises within 100 us.
// - Signal-lost output falls within 100 us.
// - Software off bit darkens laser quickly.
// - Clearing software off bit restores light.
// - Fault shown in status bit 2.
// - Signal loss shown in status bit 1.
// - Data ready bit 0 within 1000 ms.
// - Both pages answer within 300 ms.
// - Write cycle finishes within 40/80 ms.
// - Host clock at most 400 kHz.
// - Module may stretch clock; host waits.
// - Host leaves 20 us bus free.
`timescale 1ns/1ps
`default_nettype none
`include "omc_regs.svh"
module omc_module #(
  parameter int unsigned ON_CYC = `OMC_ON_CYC
) (
  input wire logic clk,
  input wire logic srst,
  omc_link_if.dev link,
  input wire logic faultDetect,
  input wire logic signalPresent,
  output logic laserOn
);

  localparam logic [17:0] ON_LIM = 18'(ON_CYC - 1);
  localparam logic [10:0] RESET_LIM = 11'(`OMC_RESET_CYC - 1);

  omc_pkg::omc_dev_t s_q, s_d;
  logic sclRise, sclFall, startCond, stopCond, txFall;

  // Contents of a readable byte; only the control and status byte holds data.
  function automatic logic [7:0] rdByte(input omc_pkg::omc_dev_t s);
    logic [7:0] b;
    b = 8'h00;
    if (s.selA2 && s.ptr == `OMC_CSB_OFS)
    begin
      b[7] = s.txS2;
      b[`OMC_CSB_SOFTOFF] = s.softOff;
      b[`OMC_CSB_FAULT] = s.faultLat;
      b[`OMC_CSB_LOS] = s.losOut;
      b[`OMC_CSB_READY] = s.ready;
    end
    return b;
  endfunction

  // Bus conditions seen on the synchronised pins.
  assign sclRise = s_q.sclS2 & ~s_q.sclPrev;
  assign sclFall = ~s_q.sclS2 & s_q.sclPrev;
  assign startCond = s_q.sclS2 & s_q.sclPrev & s_q.sdaPrev & ~s_q.sdaS2;
  assign stopCond = s_q.sclS2 & s_q.sclPrev & ~s_q.sdaPrev & s_q.sdaS2;
  assign txFall = ~s_q.txS2 & (s_q.highCnt != '0); // First low cycle after a high run.

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the whole module.
  always_comb
  begin
    s_d = s_q;
    // Two-flop synchronisers for every pin input.
    s_d.txS1 = link.txOffPin;
    s_d.txS2 = s_q.txS1;
    s_d.sclS1 = link.scl;
    s_d.sclS2 = s_q.sclS1;
    s_d.sclPrev = s_q.sclS2;
    s_d.sdaS1 = link.sda;
    s_d.sdaS2 = s_q.sdaS1;
    s_d.sdaPrev = s_q.sdaS2;
    s_d.fdS1 = faultDetect;
    s_d.fdS2 = s_q.fdS1;
    s_d.spS1 = signalPresent;
    s_d.spS2 = s_q.spS1;

    // Initialisation timer restarts on a transmit-off fall.
    if (txFall)
    begin
      s_d.onCnt = '0;
      s_d.ready = 1'b0;
    end
    else if (!s_q.ready)
    begin
      if (s_q.onCnt == ON_LIM)
      begin
        s_d.ready = 1'b1;
      end
      else
      begin
        s_d.onCnt = s_q.onCnt + 18'h00001;
      end
    end

    // Time the transmit-off pin high; a long enough pulse clears the fault.
    if (!s_q.txS2)
    begin
      s_d.highCnt = '0;
    end
    else if (s_q.highCnt != RESET_LIM)
    begin
      s_d.highCnt = s_q.highCnt + 11'h001;
    end
    else
    begin
      s_d.faultLat = 1'b0;
    end
    // A present fault wins over the clear.
    if (s_q.fdS2)
    begin
      s_d.faultLat = 1'b1;
    end

    // Laser and status pins.
    s_d.laserOn = s_q.ready & ~s_q.txS2 & ~s_q.softOff & ~s_q.faultLat;
    s_d.faultOut = s_q.faultLat;
    s_d.losOut = ~s_q.spS2;

    // Hold the clock low while the interface is not yet available.
    s_d.sclOe = ~s_q.ready & (~s_q.sclS2 | s_q.sclOe);

    // Two-wire slave.
    if (startCond)
    begin
      s_d.st = omc_pkg::SADDR;
      s_d.bitCnt = '0;
      s_d.sdaOe = 1'b0;
    end
    else if (stopCond)
    begin
      s_d.st = omc_pkg::SIDLE;
      s_d.sdaOe = 1'b0;
      // The internal write completes at the stop itself.
      if (s_q.wrPend)
      begin
        s_d.softOff = s_q.wrVal;
        s_d.wrPend = 1'b0;
      end
    end
    else
    begin
      unique case (s_q.st)
        omc_pkg::SIDLE:
        begin
          s_d.sdaOe = 1'b0;
        end
        omc_pkg::SADDR, omc_pkg::SRX:
        begin
          if (sclRise)
          begin
            s_d.shr = {s_q.shr[6:0], s_q.sdaS2};
            s_d.bitCnt = s_q.bitCnt + 4'h1;
          end
          else if (sclFall && s_q.bitCnt == 4'h8)
          begin
            s_d.st = omc_pkg::SACK;
            s_d.sdaOe = 1'b1;
            if (s_q.st == omc_pkg::SADDR)
            begin
              s_d.rw = s_q.shr[0];
              s_d.selA2 = s_q.shr[1];
              s_d.first = 1'b1;
              // Answer on both pages once ready.
              if (!s_q.ready || (s_q.shr[7:1] != `OMC_DEV_A0 >> 1 &&
                  s_q.shr[7:1] != `OMC_DEV_A2 >> 1))
              begin
                s_d.st = omc_pkg::SIDLE;
                s_d.sdaOe = 1'b0;
              end
            end
            else if (s_q.first)
            begin
              s_d.ptr = s_q.shr;
              s_d.first = 1'b0;
            end
            else
            begin
              // Only the software off bit is writable.
              if (s_q.selA2 && s_q.ptr == `OMC_CSB_OFS)
              begin
                s_d.wrPend = 1'b1;
                s_d.wrVal = s_q.shr[`OMC_CSB_SOFTOFF];
              end
              s_d.ptr = s_q.ptr + 8'h01;
            end
          end
        end
        omc_pkg::SACK, omc_pkg::SMACK:
        begin
          if (sclRise && s_q.st == omc_pkg::SMACK && s_q.sdaS2)
          begin
            s_d.st = omc_pkg::SIDLE;
          end
          else if (sclFall)
          begin
            s_d.bitCnt = '0;
            if (s_q.rw)
            begin
              s_d.st = omc_pkg::STX;
              s_d.shr = rdByte(s_q);
              s_d.sdaOe = ~s_d.shr[7];
              s_d.ptr = s_q.ptr + 8'h01;
            end
            else
            begin
              s_d.st = omc_pkg::SRX;
              s_d.sdaOe = 1'b0;
            end
          end
        end
        omc_pkg::STX:
        begin
          if (sclFall)
          begin
            s_d.bitCnt = s_q.bitCnt + 4'h1;
            s_d.shr = {s_q.shr[6:0], 1'b0};
            s_d.sdaOe = ~s_q.shr[6];
            if (s_q.bitCnt == 4'h7)
            begin
              s_d.st = omc_pkg::SMACK;
              s_d.sdaOe = 1'b0;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset; the transmit-off pin idles high.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.txS1 <= 1'b1;
      s_q.txS2 <= 1'b1;
      s_q.sclS1 <= 1'b1;
      s_q.sclS2 <= 1'b1;
      s_q.sclPrev <= 1'b1;
      s_q.sdaS1 <= 1'b1;
      s_q.sdaS2 <= 1'b1;
      s_q.sdaPrev <= 1'b1;
      s_q.spS1 <= 1'b1;
      s_q.spS2 <= 1'b1;
      s_q.st <= omc_pkg::SIDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register.
  assign laserOn = s_q.laserOn;
  assign link.laserFault = s_q.faultOut;
  assign link.rxLost = s_q.losOut;
  assign link.sclDevOe = s_q.sclOe;
  assign link.sdaDevOe = s_q.sdaOe;

endmodule
`default_nettype wire

// file: omc_asserts.sv
// Concurrent checks on the pins between the host controller and the optical module.
`timescale 1ns/1ps
`default_nettype none
module omc_asserts #(
  parameter int unsigned GAP_CYC = 300
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic txOffPin,
  input wire logic laserFault,
  input wire logic scl,
  input wire logic sda,
  input wire logic laserOn,
  input wire logic faultDetect,
  input wire logic signalPresent,
  input wire logic rxLost
);
  localparam int RESET_CYC = 1250;
  localparam int BUF_CYC = 2500;
  localparam int PER_CYC = 313;
  logic [20:0] gapQ, runQ, sclQ, freeQ;
  logic txPrevQ, sclPrevQ, sdaPrevQ;

  ////////////////////////////////////////////////////////////////////////////////
  // Counters since the last pin rise, of the last high run, since scl rise and since a stop.
  always_ff @(posedge clk)
  begin
    txPrevQ <= srst ? 1'b0 : txOffPin;
    sclPrevQ <= srst ? 1'b1 : scl;
    sdaPrevQ <= srst ? 1'b1 : sda;
    if (srst)
    begin
      gapQ <= '1;
      runQ <= '0;
      sclQ <= '1;
      freeQ <= '1;
    end
    else
    begin
      gapQ <= (txOffPin && !txPrevQ) ? 21'h1 : ((&gapQ) ? gapQ : gapQ + 21'h1);
      runQ <= !txOffPin ? runQ : (!txPrevQ ? 21'h1 : ((&runQ) ? runQ : runQ + 21'h1));
      sclQ <= (scl && !sclPrevQ) ? 21'h1 : ((&sclQ) ? sclQ : sclQ + 21'h1);
      freeQ <= (scl && sda && !sdaPrevQ) ? 21'h1 : ((&freeQ) ? freeQ : freeQ + 21'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_pinRise;
    $rose(txOffPin);
  endsequence

  property p_offFast;
    s_pinRise |-> ##[1:5] !laserOn;
  endproperty
  property p_pinOr;
    txOffPin [*6] |-> !laserOn;
  endproperty
  property p_faultPin;
    faultDetect [*6] |-> laserFault;
  endproperty
  property p_faultClr;
    $fell(laserFault) |-> runQ >= RESET_CYC;
  endproperty
  property p_losOn;
    !signalPresent [*5] |-> rxLost;
  endproperty
  property p_losOff;
    signalPresent [*5] |-> !rxLost;
  endproperty
  property p_txGap;
    s_pinRise |-> gapQ >= GAP_CYC;
  endproperty
  property p_sclRate;
    $rose(scl) |-> sclQ >= PER_CYC;
  endproperty
  property p_busFree;
    s_start |-> freeQ >= BUF_CYC;
  endproperty

  a_offFast: assert property (p_offFast)
    else $error("laser still on after transmit-off rise");
  a_pinOr: assert property (p_pinOr)
    else $error("laser on while transmit-off pin high");
  a_faultPin: assert property (p_faultPin)
    else $error("fault output missing");
  a_faultClr: assert property (p_faultClr)
    else $error("fault cleared without a long enough pulse");
  a_losOn: assert property (p_losOn)
    else $error("signal lost output missing");
  a_losOff: assert property (p_losOff)
    else $error("signal lost output stuck");
  a_txGap: assert property (p_txGap)
    else $error("transmit-off rises too close");
  a_sclRate: assert property (p_sclRate)
    else $error("two-wire clock too fast");
  a_busFree: assert property (p_busFree)
    else $error("start too soon after stop");
endmodule
`default_nettype wire

// file: omc_bench.sv
// Self-checking bench joining the host controller and the optical module.
`timescale 1ns/1ps
`default_nettype none
`include "omc_regs.svh"
module omc_bench;
  logic clk = 1'b0;
  logic srst, cyc, stb, we, ack, irq, laserOn, faultDetect, signalPresent;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  int err_total = 0;
  int compares = 0;

  omc_link_if link();
  omc_module #(.ON_CYC(200)) u_omc_module (.clk(clk), .srst(srst), .link(link),
    .faultDetect(faultDetect), .signalPresent(signalPresent), .laserOn(laserOn));
  omc_host #(.GAP_CYC(300), .READY_CYC(300)) u_omc_host (.clk(clk), .srst(srst),
    .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
  omc_asserts #(.GAP_CYC(300)) u_omc_asserts (.clk(clk), .srst(srst),
    .txOffPin(link.txOffPin), .laserFault(link.laserFault), .scl(link.scl), .sda(link.sda),
    .laserOn(laserOn), .faultDetect(faultDetect), .signalPresent(signalPresent),
    .rxLost(link.rxLost));

  // Free-running system clock.
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a difference.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic Wishbone cycle; waits for ack, only the watchdog ends a hang.
  task automatic wbCycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  // Starts a two-wire operation and polls until it is no longer busy.
  task automatic twi(input logic [31:0] cmd);
    wbCycle(1'b1, `OMC_WB_CMD, cmd);
    do
    begin
      wbCycle(1'b0, `OMC_WB_STAT, 32'h0);
    end
    while (rd[0] !== 1'b0);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial
  begin
    {srst, cyc, stb, we, faultDetect, signalPresent} = 6'h21;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    wbCycle(1'b1, `OMC_WB_MASK, 32'h7);
    wbCycle(1'b0, `OMC_WB_MASK, 32'h0);
    check(rd, 32'h7);
    wbCycle(1'b1, 8'h14, 32'hFFFFFFFF);
    wbCycle(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    repeat (400) @(posedge clk);
    wbCycle(1'b0, `OMC_WB_IRQ, 32'h0);
    check(rd, 32'h0);
    $display("test registers done");
    twi(32'h0002406E);
    repeat (8) @(posedge clk);
    check(32'(laserOn), 32'h0);
    check(32'(irq), 32'h1);
    wbCycle(1'b0, `OMC_WB_IRQ, 32'h0);
    check(rd, 32'h1);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h0);
    twi(32'h0003006E);
    check(rd[18:8], 11'h041);
    twi(32'h0002006E);
    repeat (8) @(posedge clk);
    check(32'(laserOn), 32'h1);
    $display("test software off done");
    wbCycle(1'b1, `OMC_WB_MASK, 32'h0);
    signalPresent <= 1'b0;
    repeat (10) @(posedge clk);
    check(32'(link.rxLost), 32'h1);
    check(32'(irq), 32'h0);
    wbCycle(1'b1, `OMC_WB_MASK, 32'h7);
    repeat (3) @(posedge clk);
    check(32'(irq), 32'h1);
    wbCycle(1'b0, `OMC_WB_IRQ, 32'h0);
    check(rd, 32'h5);
    twi(32'h0003006E);
    check(rd[18:8], 11'h203);
    signalPresent <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(link.rxLost), 32'h0);
    wbCycle(1'b0, `OMC_WB_IRQ, 32'h0);
    check(rd, 32'h5);
    $display("test signal loss done");
    faultDetect <= 1'b1;
    repeat (10) @(posedge clk);
    check(32'(link.laserFault), 32'h1);
    twi(32'h0003006E);
    check(rd[18:8], 11'h105);
    faultDetect <= 1'b0;
    wbCycle(1'b0, `OMC_WB_IRQ, 32'h0);
    check(rd, 32'h3);
    wbCycle(1'b1, `OMC_WB_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    check(32'(laserOn), 32'h0);
    repeat (1300) @(posedge clk);
    check(32'(link.laserFault), 32'h0);
    wbCycle(1'b1, `OMC_WB_CTRL, 32'h0);
    repeat (5) @(posedge clk);
    check(32'(link.txOffPin), 32'h0);
    repeat (100) @(posedge clk);
    check(32'(laserOn), 32'h0);
    repeat (200) @(posedge clk);
    check(32'(laserOn), 32'h1);
    // A second pin rise, now with the laser lit and the spacing kept.
    wbCycle(1'b1, `OMC_WB_CTRL, 32'h1);
    repeat (6) @(posedge clk);
    check(32'(link.txOffPin), 32'h1);
    check(32'(laserOn), 32'h0);
    $display("test transmit-off done");
    print_verdict();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule
`default_nettype wire
